// ===== hdl/sbsc_top.sv
// Control logic and storage of a synchronous burst SRAM
`timescale 1ns/1ps
// Contract
// R1: Burst order linear when burst_order_sel_n low, interleaved when high; wraps after four.
// R2: flow_through_n low bypasses output register; high gives pipelined output.
// R3: sleep_req high puts device in standby; low keeps it active.
// R4: Partial select with a strobe, or cs1 high with ctrl strobe, deselects.
// R5: Full select with proc strobe loads address, starts read, ignores writes.
// R6: Full select with ctrl strobe only loads address; write or read per qualifier.
// R7: Continue conditions with advance low step counter to next address.
// R8: Continue conditions with advance high repeat the current address.
// R9: Global write writes all lanes; gated lane writes; otherwise read.
// R10: Reads drive every byte lane regardless of lane write inputs.
// R11: Writes keep all data pins undriven.
// R12: Lanes c and d exist only in four-lane organisations.
// R13: out_en_n high turns drivers off at once, without the clock.
// R14: out_en_n low enables drivers only for read cycles.
// R15: Master may use dummy reads with out_en_n high before writing.
// R16: Reads with out_en_n high still advance the burst counter.
// R17: Master may tie proc strobe high and ctrl strobe low.
// R18: Master may tie proc strobe high, advance low, load with ctrl strobe.
// R19: Burst start presets counter from the two low address inputs.
// R20: Pipeline read data appears one clock after flow-through data.
module sbsc_top
	import sbsc_pkg::*;
#(
	parameter int ADDR_W = SBSC_ADDR_W,
	parameter int LANES = SBSC_LANES,
	parameter int LANE_W = SBSC_LANE_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic chip_sel1_n,
	input wire logic chip_sel2,
	input wire logic chip_sel3_n,
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic all_byte_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [LANES-1:0] lane_write_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic burst_order_sel_n,
	input wire logic flow_through_n,
	input wire logic sleep_req,
	input wire logic out_en_n,
	input wire logic [LANES*LANE_W-1:0] dq_in,
	output logic [LANES*LANE_W-1:0] dq_out,
	output logic dq_oe,
	output logic standby
);

	localparam int DATA_W = LANES * LANE_W;
	localparam int HI_W = ADDR_W - SBSC_BURST_W;

	////////////////////////////////////////////////////////////////////////////
	// Burst sequence

	function automatic logic [1:0] sbsc_burst_lsb(input logic [1:0] start, input logic [1:0] step,
		input logic interleave);
		sbsc_burst_lsb = interleave ? (start ^ step) : 2'(start + step);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic [DATA_W-1:0] mem_q [0:(2**ADDR_W)-1];
	logic [HI_W-1:0] hi_q;
	logic [1:0] start_q;
	logic [1:0] step_q;
	logic [1:0] step_d;
	logic [DATA_W-1:0] pipe_q;
	logic pipe_rd_q;
	logic [DATA_W-1:0] dq_out_q;
	logic oe_q;
	logic standby_q;

	wire full_sel;
	wire any_strobe;
	wire is_desel;
	wire is_begin_rd;
	wire is_begin_c;
	wire is_cont;
	wire write_qual;
	wire [LANES-1:0] lane_en;

	// Full select needs all three enables at their active levels
	assign full_sel = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
	assign any_strobe = ~proc_addr_strobe_n | ~ctrl_addr_strobe_n;
	assign is_desel = (~chip_sel1_n & ~full_sel & any_strobe) | (chip_sel1_n & ~ctrl_addr_strobe_n); // R4
	assign is_begin_rd = full_sel & ~proc_addr_strobe_n; // R5
	assign is_begin_c = full_sel & proc_addr_strobe_n & ~ctrl_addr_strobe_n; // R6
	// Chip selects are ignored once both strobes are quiet
	assign is_cont = ctrl_addr_strobe_n & (proc_addr_strobe_n | chip_sel1_n); // R7 R8
	assign write_qual = ~all_byte_write_n | ~byte_write_gate_n; // R9
	// Lanes c/d only exist when LANES is four; the port width follows LANES
	assign lane_en = ~all_byte_write_n ? {LANES{1'b1}} :
		(~byte_write_gate_n ? ~lane_write_n : {LANES{1'b0}}); // R9 R12

	sbsc_op_t op;
	assign op = sleep_req ? SBSC_OP_IDLE : // R3
		is_desel ? SBSC_OP_DESEL :
		(is_begin_rd | is_begin_c) ? SBSC_OP_BEGIN :
		(is_cont & ~burst_advance_n) ? SBSC_OP_NEXT :
		is_cont ? SBSC_OP_HOLD : SBSC_OP_IDLE;

	wire cyc_write;
	wire cyc_access;
	wire cyc_read;
	wire cyc_wr;

	// Proc strobe start is always a read, whatever the write pins say
	assign cyc_write = (op == SBSC_OP_BEGIN) ? (is_begin_c & write_qual) : write_qual; // R5 R6
	assign cyc_access = (op == SBSC_OP_BEGIN) | (op == SBSC_OP_NEXT) | (op == SBSC_OP_HOLD);
	assign cyc_read = cyc_access & ~cyc_write;
	// A write with no lanes enabled still counts as a write and stays undriven
	assign cyc_wr = cyc_access & cyc_write;

	// Counter advances on out_en_n-high reads too; nothing here looks at it
	assign step_d = (op == SBSC_OP_BEGIN) ? SBSC_STEP_RST :
		(op == SBSC_OP_NEXT) ? 2'(step_q + 2'h1) : step_q; // R1 R7 R8 R16

	wire [1:0] lsb_now;
	wire [HI_W-1:0] hi_now;
	wire [ADDR_W-1:0] acc_addr;

	// Start cycle uses the pins directly so the first access needs no extra edge
	assign lsb_now = (op == SBSC_OP_BEGIN) ? addr[1:0] :
		sbsc_burst_lsb(start_q, step_d, burst_order_sel_n); // R1 R19
	assign hi_now = (op == SBSC_OP_BEGIN) ? addr[ADDR_W-1:SBSC_BURST_W] : hi_q;
	assign acc_addr = {hi_now, lsb_now};

	wire [DATA_W-1:0] wr_mask;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign wr_mask[g*LANE_W +: LANE_W] = {LANE_W{lane_en[g]}};
		end
	endgenerate

	wire [DATA_W-1:0] rd_word;
	wire [DATA_W-1:0] wr_word;

	// Merge keeps unselected lanes; costs a read port on the write path
	assign rd_word = mem_q[acc_addr];
	assign wr_word = (rd_word & ~wr_mask) | (dq_in & wr_mask);

	////////////////////////////////////////////////////////////////////////////
	// Address and burst state

	always_ff @(posedge clk) begin
		if (srst) begin
			step_q <= SBSC_STEP_RST;
		end else begin
			step_q <= step_d; // R1 R16
		end
	end

	// Start bits are kept so the order can be applied to each step
	always_ff @(posedge clk) begin
		if (srst) begin
			start_q <= SBSC_STEP_RST;
		end else if (op == SBSC_OP_BEGIN) begin
			start_q <= addr[1:0]; // R19
		end
	end

	// Upper address bits are only captured on a burst start
	always_ff @(posedge clk) begin
		if (srst) begin
			hi_q <= '0;
		end else if (op == SBSC_OP_BEGIN) begin
			hi_q <= addr[ADDR_W-1:SBSC_BURST_W];
		end
	end

	// Storage holds no reset; contents are undefined until written
	always_ff @(posedge clk) begin
		if (cyc_wr) begin
			mem_q[acc_addr] <= wr_word; // R9
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output path

	always_ff @(posedge clk) begin
		if (srst) begin
			pipe_q <= '0;
			pipe_rd_q <= SBSC_OE_RST;
		end else begin
			pipe_q <= rd_word;
			pipe_rd_q <= cyc_read;
		end
	end

	// Mode strap is sampled every edge, so a change acts at once
	always_ff @(posedge clk) begin
		if (srst) begin
			dq_out_q <= '0;
		end else if (flow_through_n) begin
			dq_out_q <= pipe_q; // R2 R20
		end else begin
			dq_out_q <= rd_word; // R2
		end
	end

	// Drive flag follows the data through the same stage count
	always_ff @(posedge clk) begin
		if (srst) begin
			oe_q <= SBSC_OE_RST;
		end else if (flow_through_n) begin
			oe_q <= pipe_rd_q; // R14
		end else begin
			oe_q <= cyc_read; // R10 R11 R14
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			standby_q <= 1'b0;
		end else begin
			standby_q <= sleep_req; // R3
		end
	end

	assign dq_out = dq_out_q;
	// Enable is gated combinationally so out_en_n needs no clock edge to act
	assign dq_oe = oe_q & ~out_en_n; // R13 R14
	assign standby = standby_q;

endmodule

// ===== include/sbsc_pkg.sv
// Shared constants and types for the sync burst SRAM control block
package sbsc_pkg;
	localparam int SBSC_ADDR_W = 19;
	localparam int SBSC_LANES = 2;
	localparam int SBSC_LANE_W = 9;
	localparam int SBSC_BURST_W = 2;
	localparam logic [1:0] SBSC_STEP_RST = 2'h0;
	localparam logic SBSC_OE_RST = 1'b0;
	// Flow-through read is visible one edge after the command, pipeline one more
	localparam int SBSC_FLOW_LAT = 1;
	localparam int SBSC_PIPE_LAT = SBSC_FLOW_LAT + 1;

	typedef enum logic [2:0] {
		SBSC_OP_IDLE,
		SBSC_OP_DESEL,
		SBSC_OP_BEGIN,
		SBSC_OP_NEXT,
		SBSC_OP_HOLD
	} sbsc_op_t;
endpackage

// ===== verif/sbsc_properties.sv
// Port-level checks for the SRAM control block
`timescale 1ns/1ps
module sbsc_properties (
	input wire logic clk, srst, chip_sel1_n, chip_sel2, chip_sel3_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
	input wire logic all_byte_write_n, byte_write_gate_n, flow_through_n, sleep_req, out_en_n, dq_oe, standby
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	wire wr = !all_byte_write_n || !byte_write_gate_n;
	wire ft = !flow_through_n && !sleep_req;
	wire beg = sel && proc_addr_strobe_n && !ctrl_addr_strobe_n;
	wire cont = ctrl_addr_strobe_n && (proc_addr_strobe_n || chip_sel1_n);
	sequence s_rd;
		ft && (sel && !proc_addr_strobe_n || beg && !wr);
	endsequence
	AST_OE_GATE: assert property (out_en_n |-> !dq_oe) else $error("oe gate");
	AST_STANDBY: assert property (sleep_req |=> standby) else $error("standby");
	AST_SLEEP_IDLE: assert property (sleep_req && !flow_through_n |=> !dq_oe) else $error("sleep");
	AST_RD_FLOW: assert property (s_rd ##1 !out_en_n |-> dq_oe) else $error("flow read");
	AST_RD_PIPE: assert property (flow_through_n && !sleep_req && sel && !proc_addr_strobe_n ##2 !out_en_n
		|-> dq_oe) else $error("pipe read");
	AST_CONT_RD: assert property (ft && cont && !wr ##1 !out_en_n |-> dq_oe) else $error("cont read");
	AST_WR_QUIET: assert property (ft && wr && (beg || cont) |=> !dq_oe) else $error("write drive");
	AST_DESEL: assert property (ft && !sel && !cont |=> !dq_oe) else $error("deselect");
endmodule
bind sbsc_top sbsc_properties i_props (.*);

// ===== verif/sbsc_host.sv
// Bus master model driving the SRAM control inputs
`timescale 1ns/1ps
module sbsc_host (
	input wire logic clk,
	output logic [9:0] ctl = 10'h2DF,
	output logic [5:0] addr = 6'h00,
	output logic [17:0] dq_in = 18'h00000
);
	// Called at a falling edge; the rising edge between takes the command
	task cmd(input logic [9:0] c, input logic [5:0] a, input logic [17:0] d);
		ctl = c;
		addr = a;
		// Released bus shows the inverse, not a stale word
		dq_in = c[3] && c[2] ? ~dq_in : d;
		@(negedge clk);
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the sync burst SRAM control block
`timescale 1ns/1ps
module testbench;
	logic clk = 0, srst = 1, out_en_n = 0, sleep_req = 0, burst_order_sel_n = 0, flow_through_n = 0;
	logic [9:0] ctl;
	logic [5:0] addr;
	logic [17:0] dq_in, dq_out;
	logic dq_oe, standby;
	logic [1:0] s, k;
	int miscompares = 0, checks_done = 0;
	sbsc_host i_host (.clk(clk), .ctl(ctl), .addr(addr), .dq_in(dq_in));
	sbsc_top #(.ADDR_W(6)) i_dut (.*, .chip_sel1_n(ctl[9]), .chip_sel2(ctl[8]), .chip_sel3_n(ctl[7]),
		.proc_addr_strobe_n(ctl[6]), .ctrl_addr_strobe_n(ctl[5]), .burst_advance_n(ctl[4]),
		.all_byte_write_n(ctl[3]), .byte_write_gate_n(ctl[2]), .lane_write_n(ctl[1:0]));
	initial forever #2.5 clk = ~clk;
	function automatic logic [17:0] dat(input logic [5:0] a);
		return {12'hA50, a};
	endfunction
	task chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task rd(input logic [9:0] c, input logic [5:0] a, input logic [17:0] e);
		i_host.cmd(c, a, 18'h00000);
		chk(dq_out, e);
		chk(dq_oe, 1'b1);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		srst = 0;
		for (int i = 4; i < 8; i++) begin
			i_host.cmd(i > 4 ? 10'h2E7 : 10'h157, 6'h04, dat(6'(i)));
			chk(dq_oe, 1'b0);
		end
		for (int m = 0; m < 2; m++) begin
			burst_order_sel_n = m[0];
			s = 2'(m + 1);
			rd(m ? 10'h13F : 10'h15F, {4'h1, s}, dat({4'h1, s}));
			for (int i = 1; i < 6; i++) begin
				k = i > 4 ? 2'h0 : 2'(i);
				rd(i > 4 ? 10'h2FF : 10'h2EF, 6'h00, dat({4'h1, m ? s ^ k : s + k}));
			end
		end
		i_host.cmd(10'h15A, 6'h04, 18'h3FFFF);
		rd(10'h137, 6'h04, dat(6'h04) | 18'h001FF);
		out_en_n = 1;
		i_host.cmd(10'h13F, 6'h04, 18'h00000);
		chk(dq_oe, 1'b0);
		out_en_n = 0;
		rd(10'h2EF, 6'h00, dat(6'h05));
		i_host.cmd(10'h19F, 6'h00, 18'h00000);
		chk(dq_oe, 1'b0);
		i_host.cmd(10'h2DF, 6'h00, 18'h00000);
		chk(dq_oe, 1'b0);
		sleep_req = 1;
		i_host.cmd(10'h13F, 6'h06, 18'h00000);
		chk(standby, 1'b1);
		chk(dq_oe, 1'b0);
		sleep_req = 0;
		flow_through_n = 1;
		i_host.cmd(10'h13F, 6'h06, 18'h00000);
		rd(10'h2DF, 6'h00, dat(6'h06));
		end_of_test();
	end
endmodule
